/* core/fault_status.sv */
// Purpose: missed-interrupt flags and bus-fault cause register
// Assumes: one 50 MHz clock, all inputs synchronous to sys_clk
// Notes:   bus masters present each access on the check port for one cycle
//
// Function
// - missed flags reset to zero; bits 31:16 and 1:0 always read zero.
// - lines D, C, B, A set bits 15 to 12 and the converter bit 11.
// - radio receive, transmit and timer land in bits 10, 9 and 8.
// - security engine, serial ctrl 2 and serial ctrl 1 set bits 7, 6, 5.
// - sleep timer, baseband and management land in bits 4, 3 and 2.
// - fault causes reset to zero and only bits 3:0 are used.
// - a byte or halfword peripheral-bus access faults and sets bit 3.
// - an unaligned word access faults and sets cause bit 3 too.
// - an unprivileged write to protected space faults and sets bit 2.
// - an access above a block's last register faults and sets bit 1.
// - an access beyond the top of memory or flash faults and sets bit 1.
// - a fault while any cause bit is already set also sets bit 0.
`timescale 1ns/1ns
`default_nettype none

module fault_status (
  // clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   resetn,
  // register port
  input  wire logic [31:0]                            reg_addr,
  input  wire logic [31:0]                            reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic      [31:0]                            reg_rdata,
  // interrupt sources, bit n of the vectors is register bit n+2
  input  wire logic [fault_status_pkg::SRC_COUNT-1:0] irq_event,
  input  wire logic [fault_status_pkg::SRC_COUNT-1:0] irq_pending,
  // access check port from the bus fabric
  input  wire logic                                   acc_valid,
  input  wire logic [1:0]                             acc_size,
  input  wire logic [1:0]                             acc_addr_lo,
  input  wire logic                                   acc_write,
  input  wire logic                                   acc_privileged,
  input  wire logic                                   acc_periph_bus,
  input  wire logic                                   acc_system_space,
  input  wire logic                                   acc_above_last_reg,
  input  wire logic                                   acc_beyond_memory,
  output logic                                        bus_fault
);
  import fault_status_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [SRC_COUNT-1:0] missed;
    logic [CAUSE_W-1:0]   cause;
    logic [31:0]          rdata;
    logic                 fault;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic                 size_err;
  logic                 prot_err;
  logic                 map_err;
  logic                 any_err;
  logic                 wr_missed;
  logic                 wr_cause;
  logic [SRC_COUNT-1:0] missed_clr;
  logic [CAUSE_W-1:0]   cause_clr;
  logic [CAUSE_W-1:0]   cause_set;

  // ****************************************
  // fault classification
  // ****************************************
  always_comb begin
    size_err = acc_valid && acc_periph_bus &&
               (acc_size == SIZE_BYTE || acc_size == SIZE_HALF);
    if (acc_valid && acc_size == SIZE_WORD &&
        (acc_addr_lo & WORD_ALIGN_MASK) != 2'h0) begin
      size_err = 1'b1;
    end
    prot_err = acc_valid && acc_write && !acc_privileged &&
               acc_system_space;
    map_err  = acc_valid &&
               (acc_above_last_reg ||
                acc_beyond_memory);
    any_err  = size_err || prot_err || map_err;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    wr_missed  = reg_wr && reg_addr == MISSED_FLAGS_ADDR;
    wr_cause   = reg_wr && reg_addr == FAULT_CAUSE_ADDR;
    missed_clr = wr_missed ? reg_wdata[MISSED_MSB:MISSED_LSB]
                           : '0;
    cause_clr  = wr_cause ? reg_wdata[CAUSE_W-1:0] : '0;
    cause_set  = '0;
    cause_set[ACCESS_SIZE_FAULT] = size_err;
    cause_set[PROTECTION_FAULT]  = prot_err;
    cause_set[UNMAPPED_FAULT]    = map_err;
    // the state seen by the faulting access is the one before any clear
    cause_set[OVERLAP_FAULT] = any_err && (state_reg.cause != '0);

    state_next = state_reg;
    // set wins over a clear in the same cycle
    state_next.missed = (state_reg.missed & ~missed_clr) |
                        (irq_event & irq_pending);
    state_next.cause  = (state_reg.cause & ~cause_clr) | cause_set;
    state_next.fault  = any_err;

    state_next.rdata = 32'h00000000;
    if (reg_rd && reg_addr == MISSED_FLAGS_ADDR) begin
      state_next.rdata[MISSED_MSB:MISSED_LSB] = state_reg.missed;
    end else if (reg_rd && reg_addr == FAULT_CAUSE_ADDR) begin
      state_next.rdata[CAUSE_W-1:0] = state_reg.cause;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg.missed <= MISSED_RESET[MISSED_MSB:MISSED_LSB];
      state_reg.cause  <= CAUSE_RESET[CAUSE_W-1:0];
      state_reg.rdata  <= 32'h00000000;
      state_reg.fault  <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign bus_fault = state_reg.fault;

  // ****************************************
  // checks
  // ****************************************
  property p_missed_sets;
    @(posedge sys_clk) disable iff (!resetn)
      (irq_event[EXT_LINE_D_MISSED-MISSED_LSB] &&
       irq_pending[EXT_LINE_D_MISSED-MISSED_LSB])
      |=> state_reg.missed[EXT_LINE_D_MISSED-MISSED_LSB];
  endproperty
  a_missed_sets: assert property (p_missed_sets)
    else $error("line d missed flag not set");

  property p_radio_sets;
    @(posedge sys_clk) disable iff (!resetn)
      (irq_event[RADIO_RECEIVE_MISSED-MISSED_LSB] &&
       irq_pending[RADIO_RECEIVE_MISSED-MISSED_LSB])
      |=> state_reg.missed[RADIO_RECEIVE_MISSED-MISSED_LSB];
  endproperty
  a_radio_sets: assert property (p_radio_sets)
    else $error("radio receive missed flag not set");

  property p_sec_sets;
    @(posedge sys_clk) disable iff (!resetn)
      (irq_event[SECURITY_ENGINE_MISSED-MISSED_LSB] &&
       irq_pending[SECURITY_ENGINE_MISSED-MISSED_LSB])
      |=> state_reg.missed[SECURITY_ENGINE_MISSED-MISSED_LSB];
  endproperty
  a_sec_sets: assert property (p_sec_sets)
    else $error("security missed flag not set");

  property p_mgmt_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == MISSED_FLAGS_ADDR &&
       state_reg.missed[MANAGEMENT_MISSED-MISSED_LSB])
      |=> reg_rdata[MANAGEMENT_MISSED] && reg_rdata[1:0] == 2'h0;
  endproperty
  a_mgmt_read: assert property (p_mgmt_read)
    else $error("management flag not at bit 2 on read");

  sequence s_word_unaligned;
    acc_valid && acc_size == SIZE_WORD && acc_addr_lo != 2'h0;
  endsequence
  property p_unaligned;
    @(posedge sys_clk) disable iff (!resetn)
      s_word_unaligned |=> bus_fault && state_reg.cause[ACCESS_SIZE_FAULT];
  endproperty
  a_unaligned: assert property (p_unaligned)
    else $error("unaligned word access not faulted");

  property p_narrow;
    @(posedge sys_clk) disable iff (!resetn)
      (acc_valid && acc_periph_bus && acc_size == SIZE_BYTE)
      |=> bus_fault && state_reg.cause[ACCESS_SIZE_FAULT];
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("byte access to peripheral bus not faulted");

  property p_protect;
    @(posedge sys_clk) disable iff (!resetn)
      (acc_valid && acc_write && !acc_privileged && acc_system_space)
      |=> state_reg.cause[PROTECTION_FAULT];
  endproperty
  a_protect: assert property (p_protect)
    else $error("unprivileged write not faulted");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!resetn)
      (acc_valid && (acc_above_last_reg || acc_beyond_memory))
      |=> state_reg.cause[UNMAPPED_FAULT];
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not faulted");

  property p_overlap;
    @(posedge sys_clk) disable iff (!resetn)
      (any_err && state_reg.cause != '0) |=> state_reg.cause[OVERLAP_FAULT];
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("overlap bit not set");

  property p_clear_keeps;
    @(posedge sys_clk) disable iff (!resetn)
      (wr_cause && !any_err && !reg_wdata[ACCESS_SIZE_FAULT] &&
       state_reg.cause[ACCESS_SIZE_FAULT])
      |=> state_reg.cause[ACCESS_SIZE_FAULT];
  endproperty
  a_clear_keeps: assert property (p_clear_keeps)
    else $error("writing zero changed a cause flag");

  property p_cause_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == FAULT_CAUSE_ADDR)
      |=> reg_rdata[31:CAUSE_W] == '0;
  endproperty
  a_cause_read: assert property (p_cause_read)
    else $error("cause reserved bits not zero");

  property p_conv_sets;
    @(posedge sys_clk) disable iff (!resetn)
      (irq_event[CONVERTER_MISSED-MISSED_LSB] &&
       irq_pending[CONVERTER_MISSED-MISSED_LSB])
      |=> state_reg.missed[CONVERTER_MISSED-MISSED_LSB];
  endproperty
  a_conv_sets: assert property (p_conv_sets)
    else $error("converter missed flag not set");

  property p_sleep_sets;
    @(posedge sys_clk) disable iff (!resetn)
      (irq_event[SLEEP_TIMER_MISSED-MISSED_LSB] &&
       irq_pending[SLEEP_TIMER_MISSED-MISSED_LSB])
      |=> state_reg.missed[SLEEP_TIMER_MISSED-MISSED_LSB];
  endproperty
  a_sleep_sets: assert property (p_sleep_sets)
    else $error("sleep timer missed flag not set");

  property p_missed_read;
    @(posedge sys_clk) disable iff (!resetn)
      (reg_rd && reg_addr == MISSED_FLAGS_ADDR)
      |=> reg_rdata[31:MISSED_MSB+1] == '0 &&
          reg_rdata[MISSED_LSB-1:0] == '0;
  endproperty
  a_missed_read: assert property (p_missed_read)
    else $error("missed reserved bits not zero");

  // only checked when no new miss lands, since a set beats the clear
  property p_missed_clear;
    @(posedge sys_clk) disable iff (!resetn)
      (wr_missed && reg_wdata[MANAGEMENT_MISSED] &&
       !(irq_event[MANAGEMENT_MISSED-MISSED_LSB] &&
         irq_pending[MANAGEMENT_MISSED-MISSED_LSB]))
      |=> !state_reg.missed[MANAGEMENT_MISSED-MISSED_LSB];
  endproperty
  a_missed_clear: assert property (p_missed_clear)
    else $error("write one did not clear a missed flag");

  property p_beyond;
    @(posedge sys_clk) disable iff (!resetn)
      (acc_valid && acc_beyond_memory)
      |=> bus_fault && state_reg.cause[UNMAPPED_FAULT];
  endproperty
  a_beyond: assert property (p_beyond)
    else $error("access beyond memory not faulted");

  property p_half;
    @(posedge sys_clk) disable iff (!resetn)
      (acc_valid && acc_periph_bus && acc_size == SIZE_HALF)
      |=> bus_fault && state_reg.cause[ACCESS_SIZE_FAULT];
  endproperty
  a_half: assert property (p_half)
    else $error("halfword access to peripheral bus not faulted");

  // a clean aligned word access must not raise a fault pulse
  sequence s_clean_word;
    acc_valid && acc_size == SIZE_WORD && acc_addr_lo == 2'h0 &&
    !acc_above_last_reg && !acc_beyond_memory &&
    !(acc_write && !acc_privileged && acc_system_space);
  endsequence
  property p_clean_word;
    @(posedge sys_clk) disable iff (!resetn)
      s_clean_word |=> !bus_fault;
  endproperty
  a_clean_word: assert property (p_clean_word)
    else $error("aligned word access faulted");

  property p_fault_idle;
    @(posedge sys_clk) disable iff (!resetn)
      !acc_valid |=> !bus_fault;
  endproperty
  a_fault_idle: assert property (p_fault_idle)
    else $error("bus fault without an access");

  property p_first_fault;
    @(posedge sys_clk) disable iff (!resetn)
      (any_err && state_reg.cause == '0) |=> !state_reg.cause[OVERLAP_FAULT];
  endproperty
  a_first_fault: assert property (p_first_fault)
    else $error("overlap bit set on a first fault");

endmodule

`default_nettype wire

/* core/fault_status_pkg.sv */
// Purpose: constants for the missed-interrupt and bus-fault cause block
// Assumes: 32-bit register port, word addresses are byte addresses
// Notes:   register offsets are the printed addresses
package fault_status_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] MISSED_FLAGS_ADDR = 32'h4000A820;
  localparam logic [31:0] FAULT_CAUSE_ADDR  = 32'hE000ED3C;
  localparam logic [31:0] MISSED_RESET      = 32'h00000000;
  localparam logic [31:0] CAUSE_RESET       = 32'h00000000;

  // ****************************************
  // missed-interrupt field layout
  // ****************************************
  localparam int          SRC_COUNT   = 14;
  localparam int          MISSED_LSB  = 2;
  localparam int          MISSED_MSB  = 15;
  // source index = bit - MISSED_LSB
  localparam int          EXT_LINE_D_MISSED      = 15;
  localparam int          EXT_LINE_C_MISSED      = 14;
  localparam int          EXT_LINE_B_MISSED      = 13;
  localparam int          EXT_LINE_A_MISSED      = 12;
  localparam int          CONVERTER_MISSED       = 11;
  localparam int          RADIO_RECEIVE_MISSED   = 10;
  localparam int          RADIO_TRANSMIT_MISSED  = 9;
  localparam int          RADIO_TIMER_MISSED     = 8;
  localparam int          SECURITY_ENGINE_MISSED = 7;
  localparam int          SERIAL_CTRL_TWO_MISSED = 6;
  localparam int          SERIAL_CTRL_ONE_MISSED = 5;
  localparam int          SLEEP_TIMER_MISSED     = 4;
  localparam int          BASEBAND_MISSED        = 3;
  localparam int          MANAGEMENT_MISSED      = 2;

  // ****************************************
  // fault cause field layout
  // ****************************************
  localparam int          CAUSE_W            = 4;
  localparam int          ACCESS_SIZE_FAULT  = 3;
  localparam int          PROTECTION_FAULT   = 2;
  localparam int          UNMAPPED_FAULT     = 1;
  localparam int          OVERLAP_FAULT      = 0;

  // ****************************************
  // access size codes on the fault-check port
  // ****************************************
  localparam logic [1:0]  SIZE_BYTE = 2'h0;
  localparam logic [1:0]  SIZE_HALF = 2'h1;
  localparam logic [1:0]  SIZE_WORD = 2'h2;
  localparam logic [1:0]  WORD_ALIGN_MASK = 2'h3;

endpackage

/* tb/fault_partner.sv */
// Purpose: far-side model: interrupt sources and bus masters
// Assumes: fields change only by non-blocking assignment after sys_clk rise
// Notes:   released events and valid go to zero; pending and access fields show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none

module fault_partner (
  // clock
  input  wire logic                                   sys_clk,
  // interrupt sources
  output logic      [fault_status_pkg::SRC_COUNT-1:0] irq_event,
  output logic      [fault_status_pkg::SRC_COUNT-1:0] irq_pending,
  // access check port
  output logic                                        acc_valid,
  output logic      [9:0]                             acc_f
);
  import fault_status_pkg::*;
  initial begin
    irq_event   = '0;
    irq_pending = '0;
    acc_valid   = 1'b0;
    acc_f       = 10'h000;
  end

  // one cycle of events; events drop to zero so nothing new can land, pending is left inverted
  task automatic raise(input logic [SRC_COUNT-1:0] ev,
                       input logic [SRC_COUNT-1:0] pend);
    @(posedge sys_clk);
    irq_event   <= ev;
    irq_pending <= pend;
    @(posedge sys_clk);
    irq_event   <= '0;
    irq_pending <= ~pend;
  endtask

  // one access; f = size, addr_lo, write, priv, periph, system, above, beyond
  task automatic access(input logic [9:0] f);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_f     <= f;
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    acc_f     <= ~f;
  endtask
endmodule
`default_nettype wire

/* tb/fault_status_tb.sv */
// Purpose: self-checking bench for the missed-flag and fault-cause block
// Assumes: 50 MHz sys_clk, resetn held 16 cycles
// Notes:   random accesses let overlaps arise from accumulated causes
`timescale 1ns/1ns
`default_nettype none

module fault_status_tb;
  import fault_status_pkg::*;
  logic                  sys_clk, resetn, reg_wr, reg_rd, acc_valid, bus_fault;
  logic [31:0]           reg_addr, reg_wdata, reg_rdata, rd_val, exp_m;
  logic [SRC_COUNT-1:0]  irq_event, irq_pending, ev, pd;
  logic [9:0]            acc_f, f;
  logic [3:0]            exp_c, c;
  logic [31:0]           wd;
  int                    mismatches, checks_done, seed;
  logic [9:0]            dir [8] = '{10'h008, 10'h048, 10'h290, 10'h224,
                                     10'h234, 10'h204, 10'h202, 10'h201};

  fault_status u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_event(irq_event), .irq_pending(irq_pending),
    .acc_valid(acc_valid), .acc_size(acc_f[9:8]), .acc_addr_lo(acc_f[7:6]),
    .acc_write(acc_f[5]), .acc_privileged(acc_f[4]),
    .acc_periph_bus(acc_f[3]), .acc_system_space(acc_f[2]),
    .acc_above_last_reg(acc_f[1]), .acc_beyond_memory(acc_f[0]),
    .bus_fault(bus_fault));

  fault_partner u_part (
    .sys_clk(sys_clk), .irq_event(irq_event), .irq_pending(irq_pending),
    .acc_valid(acc_valid), .acc_f(acc_f));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] cause_of(input logic [9:0] a);
    cause_of = '0;
    cause_of[3] = (a[3] && a[9:8] != SIZE_WORD) ||
                  (a[9:8] == SIZE_WORD && a[7:6] != 2'h0);
    cause_of[2] = a[5] && !a[4] && a[2];
    cause_of[1] = a[1] || a[0];
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // guard against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 41385;
    {resetn, reg_wr, reg_rd} = 3'h0;
    {reg_addr, reg_wdata} = 64'h0;
    mismatches = 0;
    checks_done = 0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(MISSED_FLAGS_ADDR, rd_val);
    check("missed reset", rd_val, MISSED_RESET);
    rd(FAULT_CAUSE_ADDR, rd_val);
    check("cause reset", rd_val, CAUSE_RESET);
    exp_m = '0;
    for (int i = 0; i < SRC_COUNT; i++) begin
      u_part.raise(14'h1 << i, 14'h0);
      u_part.raise(14'h1 << i, 14'h1 << i);
      exp_m[i+MISSED_LSB] = 1'b1;
      rd(MISSED_FLAGS_ADDR, rd_val);
      check("missed bit", rd_val, exp_m);
    end
    wr(MISSED_FLAGS_ADDR + 32'h4, 32'hFFFFFFFF);
    wr(MISSED_FLAGS_ADDR, 32'h00000000);
    rd(MISSED_FLAGS_ADDR, rd_val);
    check("missed kept", rd_val, exp_m);
    rd(MISSED_FLAGS_ADDR + 32'h4, rd_val);
    check("unmapped", rd_val, 32'h0);
    // a miss and its clear on one edge: the miss must survive
    fork
      u_part.raise(14'h1, 14'h1);
      wr(MISSED_FLAGS_ADDR, 32'hFFFFFFFF);
    join
    exp_m = 32'h1 << MISSED_LSB;
    rd(MISSED_FLAGS_ADDR, rd_val);
    check("missed set wins", rd_val, exp_m);
    for (int i = 0; i < 24; i++) begin
      ev = 14'($random(seed));
      pd = 14'($random(seed));
      wd = $random(seed);
      u_part.raise(ev, pd);
      exp_m[MISSED_MSB:MISSED_LSB] |= ev & pd;
      wr(MISSED_FLAGS_ADDR, wd);
      exp_m &= ~wd;
      rd(MISSED_FLAGS_ADDR, rd_val);
      check("missed rand", rd_val, exp_m);
    end
    exp_c = '0;
    for (int i = 0; i < 40; i++) begin
      f = 10'($random(seed));
      if (f[9:8] == 2'h3) begin
        f[9:8] = SIZE_WORD;
      end
      if (i < 8) begin
        f = dir[i];
        wr(FAULT_CAUSE_ADDR, 32'h0000000F);
        exp_c = '0;
      end
      c = cause_of(f);
      u_part.access(f);
      #1;
      check("fault", 32'(bus_fault), 32'(|c));
      if (c != 4'h0 && exp_c != 4'h0) begin
        c[OVERLAP_FAULT] = 1'b1;
      end
      exp_c |= c;
      rd(FAULT_CAUSE_ADDR, rd_val);
      check("fault end", 32'(bus_fault), 32'h0);
      check("cause", rd_val, 32'(exp_c));
      if (i[1:0] == 2'h3) begin
        wd = $random(seed);
        wr(FAULT_CAUSE_ADDR, wd);
        exp_c &= ~wd[3:0];
      end
    end
    // a fault and a full clear on one edge: fault wins, old bit seen
    wr(FAULT_CAUSE_ADDR, 32'h0000000F);
    u_part.access(dir[6]);
    fork
      u_part.access(dir[0]);
      wr(FAULT_CAUSE_ADDR, 32'h0000000F);
    join
    rd(FAULT_CAUSE_ADDR, rd_val);
    check("cause set wins", rd_val, 32'h00000009);
    // reset again with both registers loaded
    u_part.raise('1, '1);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("fault in reset", 32'(bus_fault), 32'h0);
    resetn <= 1'b1;
    rd(MISSED_FLAGS_ADDR, rd_val);
    check("missed re-reset", rd_val, MISSED_RESET);
    rd(FAULT_CAUSE_ADDR, rd_val);
    check("cause re-reset", rd_val, CAUSE_RESET);
    tally_and_finish();
  end
endmodule
`default_nettype wire
